// ==== ucgf_pkg.sv ====
// Summary of operation
// - source_select picks gated, reference or pll clock
// - bits 15:8 report source actually in use
// - idle count elapses before gating request asserts
// - divider_request bits 4:0, ratio is value plus one
// - divider_current bits 20:16 show ratio in effect
// - secure and nonsecure copies act independently
// - override status bit one means gating disabled
// - bits 13, 12:9, 8, 7 name override clocks
// - bits 6, 5, 2, 0 named; others reserved
// - write one to set disables gating, zero ignored
package ucgf_pkg;
   localparam logic [11:0] UCGF_NS_CTRL_OFS = 12'h8A0; // nonsecure control
   localparam logic [11:0] UCGF_NS_DIV_OFS = 12'h8A4; // nonsecure divider
   localparam logic [11:0] UCGF_S_CTRL_OFS = 12'h8A8; // secure control
   localparam logic [11:0] UCGF_S_DIV_OFS = 12'h8AC; // secure divider
   localparam logic [11:0] UCGF_NS_IDLE_OFS = 12'h8B0; // nonsecure idle count
   localparam logic [11:0] UCGF_S_IDLE_OFS = 12'h8B4; // secure idle count
   localparam logic [11:0] UCGF_OVR_STAT_OFS = 12'hA00; // override status
   localparam logic [11:0] UCGF_OVR_SET_OFS = 12'hA04; // override set
   localparam logic [11:0] UCGF_OVR_CLR_OFS = 12'hA08; // override clear
   localparam logic [7:0] UCGF_SEL_GATED = 8'h00; // clock gated
   localparam logic [7:0] UCGF_SEL_REF = 8'h01; // reference clock
   localparam logic [7:0] UCGF_SEL_PLL = 8'h02; // system pll clock
   localparam logic [7:0] UCGF_SEL_RST = 8'h01; // control reset source
   localparam logic [4:0] UCGF_DIV_RST = 5'h1F; // divider reset request
   localparam logic [15:0] UCGF_IDLE_RST = 16'h0010; // idle count reset
   localparam int UCGF_SEL_LSB = 0; // source_select position
   localparam int UCGF_CUR_LSB = 8; // source_select_current position
   localparam int UCGF_DIV_LSB = 0; // divider_request position
   localparam int UCGF_DCUR_LSB = 16; // divider_current position
   localparam logic [31:0] UCGF_OVR_MASK = 32'h00003FE5; // implemented override bits
endpackage

// ==== ucgf_top.sv ====
`timescale 1ns/1ns
module ucgf_top
   import ucgf_pkg::*;
(
   input wire logic core_clk, // system clock
   input wire logic rstn, // async reset, active low
   input wire logic [11:0] reg_addr, // register byte address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [31:0] reg_rdata, // read data, one cycle later
   input wire logic ref_clk_en, // reference clock tick
   input wire logic pll_clk_en, // system pll clock tick
   input wire logic ns_clk_required, // nonsecure clock needed
   input wire logic s_clk_required, // secure clock needed
   output logic ns_clk_en, // nonsecure serial port clock enable
   output logic s_clk_en, // secure serial port clock enable
   output logic ns_gate_req, // nonsecure dynamic gate request
   output logic s_gate_req, // secure dynamic gate request
   output logic [31:0] gate_override // gating disabled per clock
);

   // register fields, index 0 nonsecure, index 1 secure
   logic [7:0] sel_reg [2]; // requested source code
   logic [7:0] sel_next [2]; // next requested source
   logic [4:0] div_reg [2]; // requested divider, ratio minus one
   logic [4:0] div_next [2]; // next requested divider
   logic [15:0] idle_reg [2]; // idle cycles allowed before gating
   logic [15:0] idle_next [2]; // next idle setting

   // clock generator state
   logic [7:0] cur_reg [2]; // source code in use
   logic [7:0] cur_next [2]; // next source in use
   logic [4:0] dcur_reg [2]; // divider in use
   logic [4:0] dcur_next [2]; // next divider in use
   logic [4:0] cnt_reg [2]; // source ticks within the period
   logic [4:0] cnt_next [2]; // next tick count
   logic clk_reg [2]; // output clock tick
   logic clk_next [2]; // next output tick

   // idle counter state
   logic [15:0] icnt_reg [2]; // cycles spent not required
   logic [15:0] icnt_next [2]; // next idle cycle count
   logic done_reg [2]; // idle span elapsed
   logic done_next [2]; // next elapsed flag

   // override status and gate request outputs
   logic [31:0] ovr_reg; // gating disabled per clock
   logic [31:0] ovr_next; // next override status
   logic greq_reg [2]; // gate request towards the clock gate
   logic greq_next [2]; // next gate request

   // read data
   logic [31:0] rdata_reg; // read word, stands one cycle
   logic [31:0] rdata_next; // next read word

   // helpers shared by the groups
   logic req_w [2]; // clock required per copy
   logic tick_w [2]; // tick of the source in use
   logic take_w [2]; // period boundary, new settings taken

   // write strobe aimed at one register offset
   function automatic logic wr_hit(input logic wr, input logic [11:0] addr,
         input logic [11:0] ofs);
      return wr && (addr == ofs);
   endfunction

   // control register offset of one copy
   function automatic logic [11:0] ctrl_ofs(input int copy);
      return (copy == 0) ? UCGF_NS_CTRL_OFS : UCGF_S_CTRL_OFS;
   endfunction

   // divider register offset of one copy
   function automatic logic [11:0] div_ofs(input int copy);
      return (copy == 0) ? UCGF_NS_DIV_OFS : UCGF_S_DIV_OFS;
   endfunction

   // idle count register offset of one copy
   function automatic logic [11:0] idle_ofs(input int copy);
      return (copy == 0) ? UCGF_NS_IDLE_OFS : UCGF_S_IDLE_OFS;
   endfunction

   // tick of the source named by a select code
   function automatic logic src_tick(input logic [7:0] code, input logic r,
         input logic p);
      logic t; // chosen tick
      t = 1'b0;
      case (code)
         UCGF_SEL_REF: t = r; // reference clock
         UCGF_SEL_PLL: t = p; // system pll clock
         default: t = 1'b0; // gated, reserved codes too
      endcase
      return t;
   endfunction

   // control word: source in use above source requested
   function automatic logic [31:0] ctrl_word(input logic [7:0] cur, input logic [7:0] sel);
      logic [31:0] w; // assembled word
      w = 32'h00000000; // reserved bits read zero
      w[UCGF_CUR_LSB +: 8] = cur;
      w[UCGF_SEL_LSB +: 8] = sel;
      return w;
   endfunction

   // divider word: divider in use above divider requested
   function automatic logic [31:0] div_word(input logic [4:0] dcur, input logic [4:0] dreq);
      logic [31:0] w; // assembled word
      w = 32'h00000000; // reserved bits read zero
      w[UCGF_DCUR_LSB +: 5] = dcur;
      w[UCGF_DIV_LSB +: 5] = dreq;
      return w;
   endfunction

   // demand inputs gathered per copy
   assign req_w[0] = ns_clk_required;
   assign req_w[1] = s_clk_required;

   // source tick and period boundary per copy
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         tick_w[i] = src_tick(cur_reg[i], ref_clk_en, pll_clk_en);
         // a gated copy takes new settings at once, a running one at period end
         take_w[i] = (cur_reg[i] == UCGF_SEL_GATED) ||
            (tick_w[i] && (cnt_reg[i] == dcur_reg[i]));
      end
   end

   // register fields: next values from software writes
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         sel_next[i] = sel_reg[i]; // hold by default
         div_next[i] = div_reg[i];
         idle_next[i] = idle_reg[i];
         // control register of this copy
         if (wr_hit(reg_wr, reg_addr, ctrl_ofs(i))) begin
            sel_next[i] = reg_wdata[UCGF_SEL_LSB +: 8];
         end
         // divider register of this copy
         if (wr_hit(reg_wr, reg_addr, div_ofs(i))) begin
            div_next[i] = reg_wdata[UCGF_DIV_LSB +: 5];
         end
         // idle count register of this copy
         if (wr_hit(reg_wr, reg_addr, idle_ofs(i))) begin
            idle_next[i] = reg_wdata[15:0]; // cycles before gate request
         end
      end
   end

   // register field flops
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 2; i++) begin
            sel_reg[i] <= UCGF_SEL_RST;
            div_reg[i] <= UCGF_DIV_RST;
            idle_reg[i] <= UCGF_IDLE_RST;
         end
      end else begin
         sel_reg <= sel_next;
         div_reg <= div_next;
         idle_reg <= idle_next;
      end
   end

   // clock generator: divides the tick of the source in use
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         cur_next[i] = cur_reg[i]; // hold by default
         dcur_next[i] = dcur_reg[i];
         cnt_next[i] = cnt_reg[i];
         clk_next[i] = 1'b0; // output tick lasts one cycle
         if (take_w[i]) begin
            // period boundary: adopt requested source and divider
            cur_next[i] = sel_reg[i];
            dcur_next[i] = div_reg[i];
            cnt_next[i] = 5'h00; // restart the period
            // a gated source never ticks, so no output tick then
            clk_next[i] = tick_w[i];
         end else if (tick_w[i]) begin
            // inside a period: count source ticks
            cnt_next[i] = cnt_reg[i] + 5'h01;
         end
      end
   end

   // clock generator flops
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 2; i++) begin
            cur_reg[i] <= UCGF_SEL_RST;
            dcur_reg[i] <= UCGF_DIV_RST;
            cnt_reg[i] <= 5'h00;
            clk_reg[i] <= 1'b0;
         end
      end else begin
         cur_reg <= cur_next;
         dcur_reg <= dcur_next;
         cnt_reg <= cnt_next;
         clk_reg <= clk_next;
      end
   end

   // idle counter: counts cycles while the clock is not required
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         icnt_next[i] = icnt_reg[i]; // hold by default
         done_next[i] = done_reg[i];
         if (req_w[i]) begin
            // clock in use: restart the idle span
            icnt_next[i] = 16'h0000;
            done_next[i] = 1'b0;
         end else if (icnt_reg[i] >= idle_reg[i]) begin
            // span elapsed: counter parks, request rises
            done_next[i] = 1'b1;
         end else begin
            // span still running
            icnt_next[i] = icnt_reg[i] + 16'h0001;
         end
      end
   end

   // idle counter flops
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 2; i++) begin
            icnt_reg[i] <= 16'h0000;
            done_reg[i] <= 1'b0;
         end
      end else begin
         icnt_reg <= icnt_next;
         done_reg <= done_next;
      end
   end

   // override status: clear first, so a set in the same cycle wins
   always_comb begin
      ovr_next = ovr_reg; // hold by default
      if (wr_hit(reg_wr, reg_addr, UCGF_OVR_CLR_OFS)) begin
         // write one to clear, unimplemented bits ignored
         ovr_next = ovr_next & ~(reg_wdata & UCGF_OVR_MASK);
      end
      if (wr_hit(reg_wr, reg_addr, UCGF_OVR_SET_OFS)) begin
         // write one to set, write zero leaves the bit alone
         ovr_next = ovr_next | (reg_wdata & UCGF_OVR_MASK);
      end
   end

   // override status flops
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ovr_reg <= 32'h00000000; // no override after reset
      end else begin
         ovr_reg <= ovr_next;
      end
   end

   // gate requests: the power policy override bit holds them off
   // next values are used so the request moves with the override status
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         greq_next[i] = done_next[i] && !ovr_next[0];
      end
   end

   // gate request flops
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 2; i++) begin
            greq_reg[i] <= 1'b0; // no request during reset
         end
      end else begin
         greq_reg <= greq_next;
      end
   end

   // read mux: word for the addressed register, zero without a read
   always_comb begin
      rdata_next = 32'h00000000; // idle bus reads zero
      if (reg_rd) begin
         case (reg_addr)
            UCGF_NS_CTRL_OFS: rdata_next = ctrl_word(cur_reg[0], sel_reg[0]);
            UCGF_S_CTRL_OFS: rdata_next = ctrl_word(cur_reg[1], sel_reg[1]);
            UCGF_NS_DIV_OFS: rdata_next = div_word(dcur_reg[0], div_reg[0]);
            UCGF_S_DIV_OFS: rdata_next = div_word(dcur_reg[1], div_reg[1]);
            UCGF_NS_IDLE_OFS: rdata_next = {16'h0000, idle_reg[0]}; // nonsecure idle span
            UCGF_S_IDLE_OFS: rdata_next = {16'h0000, idle_reg[1]}; // secure idle span
            UCGF_OVR_STAT_OFS: rdata_next = ovr_reg;
            default: rdata_next = 32'h00000000; // set, clear and unmapped read zero
         endcase
      end
   end

   // read data flops: the word stands one cycle only
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= 32'h00000000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // outputs, all straight from flops
   assign reg_rdata = rdata_reg;
   assign ns_clk_en = clk_reg[0];
   assign s_clk_en = clk_reg[1];
   assign ns_gate_req = greq_reg[0];
   assign s_gate_req = greq_reg[1];
   assign gate_override = ovr_reg;
endmodule

// ==== ucgf_assertions.sv ====
`timescale 1ns/1ns
module ucgf_checker (
   input wire logic core_clk, // system clock
   input wire logic rstn, // async reset, active low
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic ref_clk_en, // reference tick
   input wire logic pll_clk_en, // pll tick
   input wire logic ns_clk_required, // nonsecure demand
   input wire logic s_clk_required, // secure demand
   input wire logic ns_clk_en, // nonsecure output tick
   input wire logic s_clk_en, // secure output tick
   input wire logic ns_gate_req, // nonsecure gate request
   input wire logic s_gate_req, // secure gate request
   input wire logic [11:0] reg_addr, // byte address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic [31:0] reg_rdata, // read data
   input wire logic [31:0] gate_override // override status
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // override set access, then a long unmasked idle spell
   sequence s_ovr_set; reg_wr && reg_addr == 12'hA04; endsequence
   sequence s_long_idle; (!s_clk_required && !gate_override[0]) throughout (##20 1); endsequence
   a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not zero without read");
   a_status_read: assert property (
      reg_rd && reg_addr == 12'hA00 |=> reg_rdata == $past(gate_override))
      else $error("status read differs from override pins");
   a_set_sticks: assert property (s_ovr_set |=> (gate_override & $past(reg_wdata) &
      32'h0000_3FE5) == ($past(reg_wdata) & 32'h0000_3FE5)) else $error("override set lost");
   a_reserved_zero: assert property ((gate_override & 32'hFFFF_C01A) == 32'h0)
      else $error("reserved override bit set");
   a_ovr_holds: assert property (
      !(reg_wr && reg_addr[11:4] == 8'hA0) |=> $stable(gate_override))
      else $error("override changed without write");
   a_gate_drop: assert property (ns_clk_required |=> !ns_gate_req)
      else $error("gate request while clock required");
   a_gate_wait: assert property ($fell(s_clk_required) ##0 s_long_idle |-> s_gate_req)
      else $error("gate request missing after idle span");
   a_ns_tick_src: assert property (ns_clk_en |-> $past(ref_clk_en) || $past(pll_clk_en))
      else $error("nonsecure tick without source tick");
   a_s_tick_src: assert property (s_clk_en |-> $past(ref_clk_en) || $past(pll_clk_en))
      else $error("secure tick without source tick");
endmodule
bind ucgf_top ucgf_checker u_chk (.core_clk, .rstn, .reg_wr, .reg_rd, .ref_clk_en,
   .pll_clk_en, .ns_clk_required, .s_clk_required, .ns_clk_en, .s_clk_en, .ns_gate_req,
   .s_gate_req, .reg_addr, .reg_wdata, .reg_rdata, .gate_override);

// ==== tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
   import ucgf_pkg::*;
   logic core_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0; // clock, reset, strobes
   logic ref_clk_en = 1'b0, pll_clk_en = 1'b0, ns_clk_required = 1'b1, s_clk_required = 1'b1;
   logic [11:0] reg_addr = 12'h000; // byte address
   logic [31:0] reg_wdata = 32'h0, reg_rdata, gate_override, d, ovr = 32'h0; // data, model
   logic [31:0] lfsr = 32'h29FF9AFD; // random source
   logic ns_clk_en, s_clk_en, ns_gate_req, s_gate_req; // outputs
   logic [4:0] dv; // divider under test
   int failures = 0, num_checks = 0, nc, sc;
   always #20 core_clk = ~core_clk;
   // pll ticks every other cycle, reference every cycle
   always @(posedge core_clk) pll_clk_en <= ~pll_clk_en;
   ucgf_top u_dut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .ref_clk_en, .pll_clk_en, .ns_clk_required, .s_clk_required, .ns_clk_en, .s_clk_en,
      .ns_gate_req, .s_gate_req, .gate_override);
   function automatic logic [31:0] lfsr_next(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr_reg(logic [11:0] a, logic [31:0] v);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // reads until the value settles, bounded
   task automatic rd_chk(logic [11:0] a, logic [31:0] e);
      logic [31:0] g;
      for (int i = 0; i < 60; i++) begin
         @(posedge core_clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge core_clk);
         reg_rd <= 1'b0;
         #1 g = reg_rdata;
         if (g === e) break;
      end
      chk("register", e, g);
   endtask
   task automatic count_ticks(int cyc);
      nc = 0;
      sc = 0;
      repeat (cyc) begin
         @(posedge core_clk);
         #1 nc += ns_clk_en;
         sc += s_clk_en;
      end
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      #(40 * 20000);
      failures++;
      finish_test();
   end
   initial begin
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      ref_clk_en <= 1'b1;
      rd_chk(UCGF_NS_CTRL_OFS, 32'h0000_0101);
      rd_chk(UCGF_NS_DIV_OFS, 32'h001F_001F);
      rd_chk(12'hA04, 32'h0);
      wr_reg(UCGF_S_CTRL_OFS, 32'h0000_0002);
      rd_chk(UCGF_S_CTRL_OFS, 32'h0000_0202);
      for (int k = 0; k < 4; k++) begin
         lfsr = lfsr_next(lfsr);
         dv = (k == 0) ? 5'h00 : lfsr[4:0];
         wr_reg(UCGF_NS_DIV_OFS, {27'h0, dv});
         wr_reg(UCGF_S_DIV_OFS, {27'h0, ~dv});
         rd_chk(UCGF_NS_DIV_OFS, {11'h0, dv, 11'h0, dv});
         rd_chk(UCGF_S_DIV_OFS, {11'h0, ~dv, 11'h0, ~dv});
         count_ticks(2 * (dv + 1) * (32 - dv));
         chk("ns ticks", 2 * (32 - dv), nc);
         chk("s ticks", dv + 1, sc);
      end
      wr_reg(UCGF_S_CTRL_OFS, 32'h0);
      rd_chk(UCGF_S_CTRL_OFS, 32'h0);
      count_ticks(70);
      chk("gated ticks", 32'h0, sc);
      rd_chk(UCGF_NS_IDLE_OFS, {16'h0, UCGF_IDLE_RST});
      wr_reg(UCGF_S_IDLE_OFS, 32'h0000_0005);
      rd_chk(UCGF_S_IDLE_OFS, 32'h0000_0005);
      // request rises idle setting plus one cycles after demand falls
      @(posedge core_clk);
      ns_clk_required <= 1'b0;
      repeat (16) @(posedge core_clk);
      #1 chk("gate early", 32'h0, {31'h0, ns_gate_req});
      @(posedge core_clk);
      #1 chk("gate req", 32'h1, {31'h0, ns_gate_req});
      @(posedge core_clk);
      ns_clk_required <= 1'b1;
      s_clk_required <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk("gate drop", 32'h0, {31'h0, ns_gate_req});
      repeat (3) @(posedge core_clk);
      #1 chk("s gate early", 32'h0, {31'h0, s_gate_req});
      @(posedge core_clk);
      #1 chk("s gate req", 32'h1, {31'h0, s_gate_req});
      repeat (25) @(posedge core_clk);
      // set, clear and unmapped writes in turn
      for (int k = 0; k < 9; k++) begin
         lfsr = lfsr_next(lfsr);
         d = (k == 0) ? 32'hFFFF_FFFF : lfsr;
         wr_reg(12'hA04 + 12'(4 * (k % 3)), d);
         if (k % 3 == 0) ovr = ovr | (d & 32'h0000_3FE5);
         if (k % 3 == 1) ovr = ovr & ~d;
         rd_chk(12'hA00, ovr);
         chk("override pins", ovr, gate_override);
      end
      rd_chk(12'hA0C, 32'h0);
      chk("s gate", {31'h0, ~ovr[0]}, {31'h0, s_gate_req});
      finish_test();
   end
endmodule
